// *** core/nps_programmer.sv ***
// page, section and fuse command sequencer driven by the program and debug link
//
// Contract
// - page erase command plus trigger write erases the addressed page of its space
// - page chosen from write address only; in-page offset bits are ignored
// - page write command copies the loaded page buffer into the addressed page
// - erase-and-write erases then programs the page, atomically, never interrupted
// - section erase command plus write inside the section erases the whole section
// - busy is set from trigger until the operation has completed
// - fuse or lock write may only move bits toward a more secure setting
// - the dedicated lock-bit write command is accepted as well
// - controller registers decoded at fixed base 0x01C0 of data space
// - seven-bit command; application page codes 0x22, 0x24, 0x25, write-triggered
// - reads of the memory blocked while page erase or write runs
// - with read and write lock set, all these commands are rejected
// - write-triggered commands start on a store through the link
`timescale 1ns/10ps
module nps_programmer
	import nps_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              program_debug_link_wr_stb,
	input  wire logic [ADDR_W-1:0] program_debug_link_addr,
	input  wire logic [7:0]        program_debug_link_data,
	input  wire logic [7:0]        lock_bits,
	input  wire logic [7:0]        fuse_rd_data,
	output logic [6:0]             cmd_ff,
	output logic                   busy_ff,
	output logic                   read_block_ff,
	output nps_pkg::nps_op_t       op_ff,
	output logic                   erase_active_ff,
	output logic                   prog_active_ff,
	output logic [7:0]             fuse_wr_data_ff,
	output logic                   reject_ff
);
	import nps_pkg::*;

	// ----------------------------------------------------------------
	// decode of the incoming store
	// ----------------------------------------------------------------
	logic     in_regs;
	logic     cmd_wr;
	logic     trig;
	logic     locked;
	logic     accept;
	nps_cmd_t dec;
	logic     eng_erasing;
	logic     eng_writing;
	logic     eng_done;

	// registers live in one window at the base; everything else is memory space
	assign in_regs = (program_debug_link_addr >= NVM_BASE) &&
		(program_debug_link_addr < NVM_BASE + NVM_SPAN);
	assign cmd_wr  = program_debug_link_wr_stb && (program_debug_link_addr == NVM_BASE + CMD_OFS);
	assign trig    = program_debug_link_wr_stb && !in_regs;
	assign dec     = nps_decode(cmd_ff);
	// lock bits are programmed low; both low means read and write lock
	assign locked  = (lock_bits & LOCK_RW_MASK) == 8'h00;
	// a second trigger while busy would corrupt the running page, so drop it
	assign accept  = trig && dec.valid && !locked && !busy_ff;

	// ----------------------------------------------------------------
	// command field
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
			cmd_ff <= CMD_RST;
		else if (cmd_wr)
			cmd_ff <= program_debug_link_data[6:0];
	end

	// ----------------------------------------------------------------
	// operation capture
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			op_ff <= '{erase: 1'b0, write: 1'b0, section: 1'b0, fuse: 1'b0,
				space: SPACE_APP, page: '0, addr: '0};
		end
		else if (accept)
		begin
			op_ff.erase   <= dec.erase;
			op_ff.write   <= dec.write;
			op_ff.section <= dec.section;
			op_ff.fuse    <= dec.fuse;
			op_ff.space   <= dec.space;
			op_ff.page    <= program_debug_link_addr[ADDR_W-1:PAGE_BITS];
			op_ff.addr    <= program_debug_link_addr;
		end
	end

	// fuses move only toward programmed (zero) bits
	always_ff @(posedge core_clk)
	begin
		if (reset)
			fuse_wr_data_ff <= 8'hFF;
		else if (accept && dec.fuse)
			fuse_wr_data_ff <= fuse_rd_data & program_debug_link_data;
	end

	// ----------------------------------------------------------------
	// busy, read block and reject
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
			busy_ff <= 1'b0;
		else if (accept)
			busy_ff <= 1'b1;
		else if (eng_done)
			busy_ff <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			read_block_ff <= 1'b0;
		else if (accept && !dec.fuse)
			read_block_ff <= 1'b1;
		else if (eng_done)
			read_block_ff <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			reject_ff <= 1'b0;
		else
			reject_ff <= trig && dec.valid && locked && !busy_ff;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			erase_active_ff <= 1'b0;
			prog_active_ff  <= 1'b0;
		end
		else
		begin
			erase_active_ff <= eng_erasing;
			prog_active_ff  <= eng_writing;
		end
	end

	// ----------------------------------------------------------------
	// phase engine
	// ----------------------------------------------------------------
	nps_phase_timer u_timer
	(
		.core_clk   (core_clk),
		.reset      (reset),
		.start      (accept),
		.do_erase   (dec.erase),
		.do_write   (dec.write),
		.erasing_ff (eng_erasing),
		.writing_ff (eng_writing),
		.done_ff    (eng_done)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	AST_CMD_LOAD: assert property (cmd_wr |=> cmd_ff == $past(program_debug_link_data[6:0]))
		else $error("command field not loaded");
	AST_BUSY_SET: assert property (accept |=> busy_ff ##1 busy_ff)
		else $error("busy not raised by trigger");
	AST_BUSY_END: assert property (accept |-> ##[2:90] (busy_ff && eng_done) ##1 !busy_ff)
		else $error("busy not released at completion");
	AST_PAGE_SEL: assert property (accept |=>
		op_ff.page == $past(program_debug_link_addr[ADDR_W-1:PAGE_BITS]))
		else $error("page not taken from address");
	AST_BUSY_IGNORE: assert property ((busy_ff && trig) |=> $stable(op_ff))
		else $error("trigger accepted while busy");
	AST_LOCK_REJECT: assert property ((trig && locked && !busy_ff) |=> !busy_ff && reject_ff == dec.valid)
		else $error("command ran under lock");
	AST_ATOMIC: assert property (($fell(eng_erasing) && op_ff.write && busy_ff) |-> eng_writing)
		else $error("erase-and-write split");
	AST_READ_BLOCK: assert property ((eng_erasing || eng_writing) && !op_ff.fuse |-> read_block_ff)
		else $error("reads not blocked during page op");
	AST_FUSE_SECURE: assert property ((accept && dec.fuse) |=>
		(fuse_wr_data_ff & ~$past(fuse_rd_data)) == 8'h00)
		else $error("fuse moved to less secure value");
	AST_ERASE_FIRST: assert property ((accept && dec.erase) |=> eng_erasing)
		else $error("erase phase missing");

	COV_ERASE_WRITE: cover property (accept && dec.erase && dec.write ##[1:90] eng_done);
	COV_SECTION: cover property (accept && dec.section);
	COV_FUSE: cover property (accept && dec.fuse);
	COV_LOCKED: cover property (reject_ff);
	COV_IGNORED: cover property (busy_ff && trig);

	// ----------------------------------------------------------------
	// phase and flag consistency
	// ----------------------------------------------------------------
	// the captured op must not drift while the engine runs from it
	AST_OP_HOLD: assert property (!accept |=> $stable(op_ff))
		else $error("captured op changed without a trigger");
	AST_CMD_HOLD: assert property (!cmd_wr |=> $stable(cmd_ff))
		else $error("command field changed without a store");
	AST_BLOCK_END: assert property (eng_done |=> !busy_ff && !read_block_ff)
		else $error("busy or read block held past completion");
	AST_FUSE_NOBLOCK: assert property ((accept && dec.fuse) |=> !read_block_ff)
		else $error("fuse write blocked memory reads");
	AST_IDLE_QUIET: assert property (!busy_ff |-> !(eng_erasing || eng_writing))
		else $error("phase running while not busy");
	AST_REJECT_QUIET: assert property (reject_ff |-> !busy_ff)
		else $error("rejected command raised busy");
	AST_SECTION_ERASE: assert property ((accept && dec.section) |=>
		op_ff.section && eng_erasing && !eng_writing)
		else $error("section erase did not start as erase only");
	AST_WRITE_ONLY: assert property ((accept && dec.write && !dec.erase) |=>
		eng_writing && !eng_erasing)
		else $error("page write started without program phase");

endmodule : nps_programmer

// *** core/nps_pkg.sv ***
// shared constants, types and command decoding for the page and section programmer
package nps_pkg;

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	localparam int          ADDR_W    = 24;
	localparam int          PAGE_BITS = 8;
	localparam logic [23:0] NVM_BASE  = 24'h0001C0;
	localparam logic [23:0] NVM_SPAN  = 24'h000040;
	localparam logic [23:0] CMD_OFS   = 24'h00000A;

	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [6:0] CMD_NOP        = 7'h00;
	localparam logic [6:0] CMD_APP_SEC_ER = 7'h20;
	localparam logic [6:0] CMD_APP_PG_ER  = 7'h22;
	localparam logic [6:0] CMD_APP_PG_WR  = 7'h24;
	localparam logic [6:0] CMD_APP_PG_EW  = 7'h25;
	localparam logic [6:0] CMD_BOOT_SEC_ER = 7'h68;
	localparam logic [6:0] CMD_BOOT_PG_ER = 7'h2A;
	localparam logic [6:0] CMD_BOOT_PG_WR = 7'h2C;
	localparam logic [6:0] CMD_BOOT_PG_EW = 7'h2D;
	localparam logic [6:0] CMD_USIG_ER    = 7'h18;
	localparam logic [6:0] CMD_USIG_WR    = 7'h1A;
	localparam logic [6:0] CMD_FUSE_WR    = 7'h4C;
	localparam logic [6:0] CMD_LOCK_WR    = 7'h08;
	localparam logic [6:0] CMD_EEP_SEC_ER = 7'h30;
	localparam logic [6:0] CMD_EEP_PG_ER  = 7'h32;
	localparam logic [6:0] CMD_EEP_PG_WR  = 7'h34;
	localparam logic [6:0] CMD_EEP_PG_EW  = 7'h35;

	// ----------------------------------------------------------------
	// lock field and timing
	// ----------------------------------------------------------------
	localparam logic [7:0]  LOCK_RW_MASK = 8'h03;
	localparam logic [15:0] ERASE_CYC    = 16'h0028;
	localparam logic [15:0] WRITE_CYC    = 16'h0028;
	localparam logic [6:0]  CMD_RST      = 7'h00;

	typedef enum logic [2:0]
	{
		SPACE_APP  = 3'h0,
		SPACE_BOOT = 3'h1,
		SPACE_USIG = 3'h2,
		SPACE_EEP  = 3'h3,
		SPACE_FUSE = 3'h4
	} nps_space_t;

	typedef struct packed
	{
		logic       valid;
		logic       erase;
		logic       write;
		logic       section;
		logic       fuse;
		nps_space_t space;
	} nps_cmd_t;

	typedef struct packed
	{
		logic                        erase;
		logic                        write;
		logic                        section;
		logic                        fuse;
		nps_space_t                  space;
		logic [ADDR_W-PAGE_BITS-1:0] page;
		logic [ADDR_W-1:0]           addr;
	} nps_op_t;

	function automatic nps_cmd_t nps_decode(input logic [6:0] code);
		nps_cmd_t d;
		d = '{valid: 1'b1, erase: 1'b0, write: 1'b0, section: 1'b0, fuse: 1'b0,
			space: SPACE_APP};
		case (code)
			CMD_APP_SEC_ER:  begin d.erase = 1'b1; d.section = 1'b1; end
			CMD_APP_PG_ER:   d.erase = 1'b1;
			CMD_APP_PG_WR:   d.write = 1'b1;
			CMD_APP_PG_EW:   begin d.erase = 1'b1; d.write = 1'b1; end
			CMD_BOOT_SEC_ER: begin d.erase = 1'b1; d.section = 1'b1; d.space = SPACE_BOOT; end
			CMD_BOOT_PG_ER:  begin d.erase = 1'b1; d.space = SPACE_BOOT; end
			CMD_BOOT_PG_WR:  begin d.write = 1'b1; d.space = SPACE_BOOT; end
			CMD_BOOT_PG_EW:  begin d.erase = 1'b1; d.write = 1'b1; d.space = SPACE_BOOT; end
			CMD_USIG_ER:     begin d.erase = 1'b1; d.space = SPACE_USIG; end
			CMD_USIG_WR:     begin d.write = 1'b1; d.space = SPACE_USIG; end
			CMD_EEP_SEC_ER:  begin d.erase = 1'b1; d.section = 1'b1; d.space = SPACE_EEP; end
			CMD_EEP_PG_ER:   begin d.erase = 1'b1; d.space = SPACE_EEP; end
			CMD_EEP_PG_WR:   begin d.write = 1'b1; d.space = SPACE_EEP; end
			CMD_EEP_PG_EW:   begin d.erase = 1'b1; d.write = 1'b1; d.space = SPACE_EEP; end
			CMD_FUSE_WR,
			CMD_LOCK_WR:     begin d.write = 1'b1; d.fuse = 1'b1; d.space = SPACE_FUSE; end
			default:         d.valid = 1'b0;
		endcase
		return d;
	endfunction : nps_decode

endpackage : nps_pkg

// *** core/nps_phase_timer.sv ***
// erase and program phase sequencer with fixed phase lengths
`timescale 1ns/10ps
module nps_phase_timer
	import nps_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic start,
	input  wire logic do_erase,
	input  wire logic do_write,
	output logic      erasing_ff,
	output logic      writing_ff,
	output logic      done_ff
);

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b001,
		ST_ERASE = 3'b010,
		ST_WRITE = 3'b100
	} nps_phase_t;

	nps_phase_t  state_ff;
	logic [15:0] cnt_ff;
	logic        want_write_ff;

	// ----------------------------------------------------------------
	// phase walk; no abort input, so erase-then-write cannot be split
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state_ff      <= ST_IDLE;
			cnt_ff        <= 16'h0000;
			want_write_ff <= 1'b0;
			done_ff       <= 1'b0;
		end
		else
		begin
			done_ff <= 1'b0;
			case (state_ff)
				ST_IDLE:
				begin
					if (start)
					begin
						want_write_ff <= do_write;
						state_ff      <= do_erase ? ST_ERASE : ST_WRITE;
						cnt_ff        <= do_erase ? ERASE_CYC - 16'h0001 : WRITE_CYC - 16'h0001;
					end
				end
				ST_ERASE:
				begin
					if (cnt_ff != 16'h0000)
						cnt_ff <= cnt_ff - 16'h0001;
					else if (want_write_ff)
					begin
						state_ff <= ST_WRITE;
						cnt_ff   <= WRITE_CYC - 16'h0001;
					end
					else
					begin
						state_ff <= ST_IDLE;
						done_ff  <= 1'b1;
					end
				end
				ST_WRITE:
				begin
					if (cnt_ff != 16'h0000)
						cnt_ff <= cnt_ff - 16'h0001;
					else
					begin
						state_ff <= ST_IDLE;
						done_ff  <= 1'b1;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			erasing_ff <= 1'b0;
			writing_ff <= 1'b0;
		end
		else
		begin
			erasing_ff <= (state_ff == ST_IDLE && start && do_erase) ||
				(state_ff == ST_ERASE && (cnt_ff != 16'h0000));
			writing_ff <= (state_ff == ST_IDLE && start && !do_erase) ||
				(state_ff == ST_ERASE && cnt_ff == 16'h0000 && want_write_ff) ||
				(state_ff == ST_WRITE && (cnt_ff != 16'h0000));
		end
	end

endmodule : nps_phase_timer

// *** bench/nps_link_model.sv ***
// behavioural model of the program and debug link controller issuing byte stores
`timescale 1ns/10ps
module nps_link_model
	import nps_pkg::*;
(
	input  wire logic              core_clk,
	output logic                   wr_stb,
	output logic [ADDR_W-1:0]      addr,
	output logic [7:0]             data
);
	import nps_pkg::*;

	initial
	begin
		wr_stb = 1'b0;
		addr   = 24'h000000;
		data   = 8'h00;
	end

	// ----------------------------------------------------------------
	// one byte store, one cycle strobe
	// ----------------------------------------------------------------
	// released lines show the inverse so a stale value is never mistaken
	task automatic store(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		wr_stb = 1'b1;
		addr   = a;
		data   = d;
		@(posedge core_clk);
		#1;
		wr_stb = 1'b0;
		addr   = ~a;
		data   = ~d;
	endtask : store

	// command code goes in first, trigger store after it
	task automatic run(input logic [6:0] c, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		store(NVM_BASE + CMD_OFS, {1'b0, c});
		store(a, d);
	endtask : run

endmodule : nps_link_model

// *** bench/test_nvm_page_section_programmer.sv ***
// self-checking bench for the page and section command sequencer
`timescale 1ns/10ps
module test_nvm_page_section_programmer;
	import nps_pkg::*;

	logic        core_clk;
	logic        reset;
	logic        wr_stb;
	logic [23:0] addr;
	logic [7:0]  data;
	logic [7:0]  lock_bits;
	logic [7:0]  fuse_rd_data;
	logic [6:0]  cmd_ff;
	logic        busy_ff;
	logic        read_block_ff;
	nps_op_t     op_ff;
	logic        erase_active_ff;
	logic        prog_active_ff;
	logic [7:0]  fuse_wr_data_ff;
	logic        reject_ff;
	int          num_errors;
	int          checks_done;

	nps_link_model u_link (.core_clk(core_clk), .wr_stb(wr_stb), .addr(addr), .data(data));

	nps_programmer u_dut (
		.core_clk(core_clk), .reset(reset), .program_debug_link_wr_stb(wr_stb),
		.program_debug_link_addr(addr), .program_debug_link_data(data),
		.lock_bits(lock_bits), .fuse_rd_data(fuse_rd_data), .cmd_ff(cmd_ff),
		.busy_ff(busy_ff), .read_block_ff(read_block_ff), .op_ff(op_ff),
		.erase_active_ff(erase_active_ff), .prog_active_ff(prog_active_ff),
		.fuse_wr_data_ff(fuse_wr_data_ff), .reject_ff(reject_ff));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic results;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results

	task automatic tick;
		@(posedge core_clk);
		#1;
	endtask : tick

	// counts cycles of busy; bounded so a stuck flag cannot hang the run
	task automatic wait_idle(output int n);
		n = 0;
		while (busy_ff === 1'b1 && n < 500)
		begin
			tick();
			n++;
		end
	endtask : wait_idle

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_page_erase;
		int n;
		u_link.run(CMD_APP_PG_ER, 24'h0012F7, 8'h5A);
		tick();
		check("busy", busy_ff, 1);
		check("rd_block", read_block_ff, 1);
		check("page", op_ff.page, 16'h0012);
		check("addr", op_ff.addr, 24'h0012F7);
		check("ew", {op_ff.erase, op_ff.write, op_ff.section}, 3'b100);
		tick();
		check("erasing", erase_active_ff, 1);
		wait_idle(n);
		check("busy_len", n >= ERASE_CYC - 1 && n <= ERASE_CYC + 4, 1);
		check("rd_free", read_block_ff, 0);
	endtask : t_page_erase

	task automatic t_erase_write;
		int n;
		int first_er;
		int first_pr;
		first_er = -1;
		first_pr = -1;
		u_link.run(CMD_APP_PG_EW, 24'h00AB00, 8'h00);
		u_link.store(24'h003344, 8'h00);
		check("page_kept", op_ff.page, 16'h00AB);
		n = 0;
		while (busy_ff === 1'b1 && n < 500)
		begin
			if (erase_active_ff === 1'b1 && first_er < 0)
				first_er = n;
			if (prog_active_ff === 1'b1 && first_pr < 0)
				first_pr = n;
			tick();
			n++;
		end
		check("er_then_pr", first_er >= 0 && first_pr > first_er, 1);
		check("ew_len", n >= 2 * WRITE_CYC - 4 && n <= 2 * WRITE_CYC + 4, 1);
	endtask : t_erase_write

	// every page and section code with its expected erase, write, section, space
	task automatic t_all_codes;
		logic [13:0] tab [14];
		int          n;
		tab = '{{CMD_APP_SEC_ER, 4'hA, 3'h0}, {CMD_APP_PG_ER, 4'h8, 3'h0},
			{CMD_APP_PG_WR, 4'h4, 3'h0}, {CMD_APP_PG_EW, 4'hC, 3'h0},
			{CMD_BOOT_SEC_ER, 4'hA, 3'h1}, {CMD_BOOT_PG_ER, 4'h8, 3'h1},
			{CMD_BOOT_PG_WR, 4'h4, 3'h1}, {CMD_BOOT_PG_EW, 4'hC, 3'h1},
			{CMD_USIG_ER, 4'h8, 3'h2}, {CMD_USIG_WR, 4'h4, 3'h2},
			{CMD_EEP_SEC_ER, 4'hA, 3'h3}, {CMD_EEP_PG_ER, 4'h8, 3'h3},
			{CMD_EEP_PG_WR, 4'h4, 3'h3}, {CMD_EEP_PG_EW, 4'hC, 3'h3}};
		foreach (tab[i])
		begin
			u_link.run(tab[i][13:7], 24'h04560F + 24'(i), 8'h00);
			tick();
			check("code", {op_ff.erase, op_ff.write, op_ff.section, op_ff.fuse,
				op_ff.space}, tab[i][6:0]);
			check("busy_c", busy_ff, 1);
			wait_idle(n);
		end
	endtask : t_all_codes

	task automatic t_fuse_lock;
		int n;
		fuse_rd_data = 8'hF3;
		u_link.run(CMD_FUSE_WR, 24'h008F20, 8'h5C);
		tick();
		check("fuse_val", fuse_wr_data_ff, 8'h50);
		check("fuse_rb", {busy_ff, read_block_ff, op_ff.fuse}, 3'b101);
		wait_idle(n);
		fuse_rd_data = 8'h3F;
		u_link.run(CMD_LOCK_WR, 24'h008F27, 8'hFC);
		tick();
		check("lock_val", fuse_wr_data_ff, 8'h3C);
		check("lock_busy", busy_ff, 1);
		wait_idle(n);
	endtask : t_fuse_lock

	task automatic t_locked;
		int n;
		lock_bits = 8'hFC;
		u_link.run(CMD_APP_PG_WR, 24'h001100, 8'h00);
		check("reject", {reject_ff, busy_ff}, 2'b10);
		tick();
		check("reject_end", {reject_ff, busy_ff}, 2'b00);
		lock_bits = 8'hFE;
		u_link.run(CMD_APP_PG_WR, 24'h001100, 8'h00);
		check("one_lock", {reject_ff, busy_ff}, 2'b01);
		wait_idle(n);
		lock_bits = 8'hFF;
	endtask : t_locked

	task automatic t_ignored;
		u_link.store(NVM_BASE + CMD_OFS, 8'hFF);
		check("cmd7", cmd_ff, 7'h7F);
		u_link.store(24'h001200, 8'h00);
		tick();
		check("unknown", busy_ff, 0);
		u_link.store(NVM_BASE + CMD_OFS, {1'b0, CMD_APP_PG_ER});
		u_link.store(NVM_BASE + 24'h000001, 8'h00);
		tick();
		check("in_nvm", {busy_ff, cmd_ff}, {1'b0, CMD_APP_PG_ER});
	endtask : t_ignored

	// ----------------------------------------------------------------
	// clock, reset, sequence, watchdog
	// ----------------------------------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	initial
	begin
		num_errors   = 0;
		checks_done  = 0;
		reset        = 1'b1;
		lock_bits    = 8'hFF;
		fuse_rd_data = 8'hFF;
		repeat (12) @(posedge core_clk);
		#1;
		reset = 1'b0;
		check("rst", {cmd_ff, busy_ff, read_block_ff, reject_ff, erase_active_ff,
			prog_active_ff, fuse_wr_data_ff}, {7'h00, 5'h00, 8'hFF});
		check("rst_op", {op_ff.erase, op_ff.write, op_ff.section, op_ff.fuse,
			op_ff.space, op_ff.page}, 23'h000000);
		check("rst_addr", op_ff.addr, 24'h000000);
		t_page_erase();
		t_erase_write();
		t_all_codes();
		t_fuse_lock();
		t_locked();
		t_ignored();
		results();
	end

	// the full run needs well under 3000 cycles
	initial
	begin
		#(50 * 6000);
		num_errors++;
		results();
	end

endmodule : test_nvm_page_section_programmer
